// ===== rtl/mqf_params.svh
`ifndef MQF_PARAMS_SVH
`define MQF_PARAMS_SVH

// ==========================================
// register byte offsets
`define MQF_THRESH_OFS  8'h00
`define MQF_STATUS_OFS  8'h04

// ==========================================
// field positions
`define MQF_AE_LSB      0
`define MQF_AF_LSB      8
`define MQF_ST_RQ_LSB   0
`define MQF_ST_WQ_LSB   8
`define MQF_ST_RDEV     16
`define MQF_ST_WDEV     17
`define MQF_ST_POLL     18
`define MQF_ST_ID_LSB   21
`define MQF_ST_MAST     24

// ==========================================
// reset values and sizes
`define MQF_AE_RST      8'h02
`define MQF_AF_RST      8'h02
`define MQF_QUEUES      32
`define MQF_DEPTH       16
`define MQF_DWIDTH      18
`define MQF_QUADS       4
`define MQF_SYNC_STAGES 2

`endif

// ===== rtl/mqf_pkg.sv
package mqf_pkg;

   // pin inputs as seen after the two-flop synchroniser
   typedef struct packed {
      logic [7:0]  raddr;
      logic        rlatch;
      logic        estb;
      logic        ren_n;
      logic        oe_n;
      logic [7:0]  waddr;
      logic        wlatch;
      logic        fstb;
      logic        wen_n;
      logic [17:0] din;
      logic        pclr_n;
      logic        mrs_n;
      logic        style;
      logic [2:0]  chain;
      logic        master;
      logic        etok;
      logic        ftok;
   } mqf_pins_t;

   typedef enum logic [0:0] {
      MQF_WAIT = 1'b0,
      MQF_RUN  = 1'b1
   } mqf_poll_t;

endpackage

// ===== rtl/mqf_top.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mqf_params.svh"
// Functional notes
// [R1] flag pins low when selected queue almost
// [R2] flag pins updated on the port clock
// [R3] eight-line empty bus shows one quadrant
// [R4] eight-line full bus shows one quadrant
// [R5] bus style sampled at reset, buses tristate
// [R6] direct: empty strobe picks empty quadrant
// [R7] direct: full strobe picks full quadrant
// [R8] polled: empty bus steps quadrant each cycle
// [R9] polled: full bus steps quadrant each cycle
// [R10] queue selected two cycles before clear
// [R11] clear input held low one cycle
// [R12] clear resets only that queue's pointers
// [R13] data out when read enabled and selected; a master also drives it unselected while read latch is low
// [R14] read latch high adopts new read queue
// [R15] read latch only during queue changes
// [R16] read latch never with empty strobe
// [R17] no selection before serial programming done
// [R18] read clock runs free
// [R19] poll sync and tokens on read clock
// [R20] low five address bits pick queue
// [R21] upper three bits must match chain code
// [R22] select edge may show previous queue word
// [R23] new queue data two edges after select
// [R24] chain code latched at master reset
// [R25] valid flag lags select, high when empty
// [R26] cleared queue reports empty
module mqf_top
   import mqf_pkg::*;
#(
   parameter int DEPTH = `MQF_DEPTH
) (
   input  wire logic        core_clk,              // 40 MHz clock
   input  wire logic        rst,                   // sync reset
   input  wire logic        hsel,                  // ahb select
   input  wire logic [7:0]  haddr,                 // ahb address
   input  wire logic [1:0]  htrans,                // ahb transfer type
   input  wire logic        hwrite,                // ahb write
   input  wire logic [2:0]  hsize,                 // ahb size
   input  wire logic [31:0] hwdata,                // ahb write data
   input  wire logic        hready,                // ahb bus ready
   output logic      [31:0] hrdata,                // ahb read data
   output logic             hreadyout,             // ahb slave ready
   output logic             hresp,                 // ahb response
   input  wire logic [7:0]  read_address_bus,      // read queue address
   input  wire logic        read_queue_latch,      // read select enable
   input  wire logic        empty_quadrant_strobe, // empty quadrant pick
   input  wire logic        read_en_n,             // read enable
   input  wire logic        out_en_n,              // data out enable
   input  wire logic [7:0]  write_address_bus,     // write queue address
   input  wire logic        write_queue_latch,     // write select enable
   input  wire logic        full_quadrant_strobe,  // full quadrant pick
   input  wire logic        write_en_n,            // write enable
   input  wire logic [17:0] data_in,               // write data
   input  wire logic        queue_pointer_clear_n, // partial reset
   input  wire logic        master_reset_n,        // master reset
   input  wire logic        flag_bus_style,        // 1 = polled
   input  wire logic [2:0]  chain_position_code,   // device id
   input  wire logic        master_dev,            // master device
   input  wire logic        empty_token_in,        // empty bus token
   input  wire logic        full_token_in,         // full bus token
   output logic      [17:0] data_out,              // read data
   output logic             data_out_oe,           // data drive enable
   output logic             output_valid_flag_n,   // low = data valid
   output logic             output_valid_oe,       // valid flag drive
   output logic             almost_empty_pin_n,    // read queue almost empty
   output logic             almost_full_pin_n,     // write queue almost full
   output logic      [7:0]  empty_quadrant_bus_n,  // empty flag quadrant
   output logic             empty_quadrant_oe,     // empty bus drive
   output logic      [7:0]  full_quadrant_bus_n,   // full flag quadrant
   output logic             full_quadrant_oe,      // full bus drive
   output logic             empty_poll_sync,       // empty poll wrap pulse
   output logic             empty_token_out,       // empty bus token
   output logic             full_poll_sync,        // full poll wrap pulse
   output logic             full_token_out         // full bus token
);
   import mqf_pkg::*;

   localparam int PW = $clog2(DEPTH) + 1;
   localparam int AW = $clog2(`MQF_QUEUES * DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 128) begin : g_chk
      $error("DEPTH must be a power of two from 2 to 128");
   end

   // ==========================================
   // pin synchroniser
   mqf_pins_t pin_raw;
   mqf_pins_t meta_q;
   mqf_pins_t p;

   assign pin_raw = '{raddr: read_address_bus, rlatch: read_queue_latch,
                      estb: empty_quadrant_strobe, ren_n: read_en_n,
                      oe_n: out_en_n, waddr: write_address_bus,
                      wlatch: write_queue_latch, fstb: full_quadrant_strobe,
                      wen_n: write_en_n, din: data_in,
                      pclr_n: queue_pointer_clear_n, mrs_n: master_reset_n,
                      style: flag_bus_style, chain: chain_position_code,
                      master: master_dev, etok: empty_token_in,
                      ftok: full_token_in};

   always_ff @(posedge core_clk) begin
      meta_q <= pin_raw;
      p      <= meta_q;
   end

   // ==========================================
   // master reset configuration
   logic       poll_q;
   logic [2:0] chain_q;
   logic       mast_q;
   logic       mrs_act;
   logic       start_q;

   assign mrs_act = rst | ~p.mrs_n;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         poll_q  <= 1'b0;
         chain_q <= 3'h0;
         mast_q  <= 1'b0;
      end else if (~p.mrs_n) begin
         poll_q  <= p.style;  // see [R5]
         chain_q <= p.chain;  // see [R24]
         mast_q  <= p.master;
      end
   end

   // master opens polling once after each master reset
   always_ff @(posedge core_clk) begin
      if (mrs_act) start_q <= 1'b1;
      else start_q <= 1'b0;
   end

   // ==========================================
   // register bus
   logic [7:0]  ae_off_q;
   logic [7:0]  af_off_q;
   logic        dph_q;
   logic        dwr_q;
   logic [7:0]  dadr_q;
   logic [31:0] status;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dph_q     <= 1'b0;
         dwr_q     <= 1'b0;
         dadr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
      end else if (dph_q) begin
         dph_q     <= 1'b0;
         hreadyout <= 1'b1;
         if (!dwr_q) begin
            case (dadr_q)
               `MQF_THRESH_OFS: hrdata <= {16'h0000, af_off_q, ae_off_q};
               `MQF_STATUS_OFS: hrdata <= status;
               default:         hrdata <= 32'h0000_0000;
            endcase
         end
      end else if (hsel && htrans[1] && hready) begin
         // one wait state keeps hrdata a plain flop
         dph_q     <= 1'b1;
         dwr_q     <= hwrite;
         dadr_q    <= haddr;
         hreadyout <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ae_off_q <= `MQF_AE_RST;
         af_off_q <= `MQF_AF_RST;
      end else if (dph_q && dwr_q && dadr_q == `MQF_THRESH_OFS) begin
         ae_off_q <= hwdata[`MQF_AE_LSB +: 8];
         af_off_q <= hwdata[`MQF_AF_LSB +: 8];
      end
   end

   always_ff @(posedge core_clk) begin
      hresp <= 1'b0;
   end

   // ==========================================
   // queue selection
   logic [4:0] rq_q;
   logic [4:0] rq_d1_q;
   logic       rdev_q;
   logic [4:0] wq_q;
   logic       wdev_q;

   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         rq_q   <= 5'h00;
         rdev_q <= 1'b0;
      end else if (p.rlatch) begin  // see [R14]
         rdev_q <= (p.raddr[7:5] == chain_q);  // see [R21]
         if (p.raddr[7:5] == chain_q) rq_q <= p.raddr[4:0];  // see [R20]
      end
   end

   // second stage of the read pipe; the select edge still serves the old queue
   always_ff @(posedge core_clk) begin
      if (mrs_act) rq_d1_q <= 5'h00;
      else rq_d1_q <= rq_q;  // see [R22]
   end

   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         wq_q   <= 5'h00;
         wdev_q <= 1'b0;
      end else if (p.wlatch) begin
         wdev_q <= (p.waddr[7:5] == chain_q);  // see [R21]
         if (p.waddr[7:5] == chain_q) wq_q <= p.waddr[4:0];
      end
   end

   assign status = {7'h00, mast_q, chain_q, 2'b00, poll_q, wdev_q, rdev_q,
                    3'h0, wq_q, 3'h0, rq_q};

   // ==========================================
   // queue storage and pointers
   logic [17:0]   mem [`MQF_QUEUES * DEPTH];
   logic [PW-1:0] wptr_q [`MQF_QUEUES];
   logic [PW-1:0] rptr_q [`MQF_QUEUES];
   logic [31:0]   ae_vec;
   logic [31:0]   af_vec;
   logic [31:0]   full_vec;
   logic [31:0]   nonempty_vec;
   logic          push;
   logic          pop;
   logic          pclr;
   logic [PW-1:0] rhead;
   logic [PW-1:0] rnext;

   for (genvar i = 0; i < `MQF_QUEUES; i++) begin : g_q
      logic [PW-1:0] cnt;
      assign cnt             = wptr_q[i] - rptr_q[i];
      assign nonempty_vec[i] = cnt != '0;
      assign full_vec[i]     = cnt == PW'(DEPTH);
      assign ae_vec[i]       = 9'(cnt) <= {1'b0, ae_off_q};  // see [R26]
      assign af_vec[i]       = 9'(cnt) + {1'b0, af_off_q} >= 9'(DEPTH);
   end

   assign pclr  = ~p.pclr_n;
   assign push  = ~p.wen_n & wdev_q & ~full_vec[wq_q];
   assign pop   = ~p.ren_n & rdev_q & nonempty_vec[rq_d1_q];  // see [R13]
   assign rhead = rptr_q[rq_d1_q];
   assign rnext = pop ? rhead + 1'b1 : rhead;

   always_ff @(posedge core_clk) begin
      if (push) mem[AW'({wq_q, wptr_q[wq_q][PW-2:0]})] <= p.din;
   end

   // partial clear targets the queue held on the write port, for both pointers
   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         for (int i = 0; i < `MQF_QUEUES; i++) wptr_q[i] <= '0;
      end else if (pclr) begin
         wptr_q[wq_q] <= '0;  // see [R12]
      end else if (push) begin
         wptr_q[wq_q] <= wptr_q[wq_q] + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         for (int i = 0; i < `MQF_QUEUES; i++) rptr_q[i] <= '0;
      end else if (pclr) begin
         rptr_q[wq_q] <= '0;  // see [R12]
      end else if (pop) begin
         rptr_q[rq_d1_q] <= rhead + 1'b1;
      end
   end

   // ==========================================
   // read data and valid flag
   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         data_out            <= 18'h0_0000;
         output_valid_flag_n <= 1'b1;
      end else begin
         // head of the queue falls through whatever read enable does
         data_out            <= mem[AW'({rq_d1_q, rnext[PW-2:0]})];  // see [R23]
         output_valid_flag_n <= (wptr_q[rq_d1_q] == rnext) | ~rdev_q;  // see [R25]
      end
   end

   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         data_out_oe     <= 1'b0;
         output_valid_oe <= 1'b0;
      end else begin
         data_out_oe     <= ~p.oe_n & (rdev_q | (mast_q & ~p.rlatch));
         output_valid_oe <= rdev_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (mrs_act) begin
         almost_empty_pin_n <= 1'b1;
         almost_full_pin_n  <= 1'b1;
      end else begin
         almost_empty_pin_n <= ~ae_vec[rq_q];  // see [R1] [R2]
         almost_full_pin_n  <= ~af_vec[wq_q];  // see [R1] [R2]
      end
   end

   // ==========================================
   // quadrant flag buses, index 0 empty side, 1 full side
   logic [7:0] qbus_q [2];
   logic [1:0] qoe_q;
   logic [1:0] qsync_q;
   logic [1:0] qtok_q;

   for (genvar g = 0; g < 2; g++) begin : g_bus
      mqf_poll_t  st_q;
      logic [1:0] quad_q;
      logic [31:0] vec;
      logic        stb;
      logic        tok;
      logic [7:0]  adr;

      assign vec = (g == 0) ? ae_vec : af_vec;
      assign stb = (g == 0) ? p.estb : p.fstb;
      assign tok = (g == 0) ? p.etok : p.ftok;
      assign adr = (g == 0) ? p.raddr : p.waddr;

      always_ff @(posedge core_clk) begin
         if (mrs_act) begin
            st_q       <= MQF_WAIT;
            quad_q     <= 2'b00;
            qoe_q[g]   <= 1'b0;
            qsync_q[g] <= 1'b0;
            qtok_q[g]  <= 1'b0;
         end else if (!poll_q) begin
            qsync_q[g] <= 1'b0;
            qtok_q[g]  <= 1'b0;
            if (stb) begin  // see [R6] [R7]
               quad_q   <= adr[1:0];
               qoe_q[g] <= adr[7:5] == chain_q;  // see [R5]
            end
         end else begin
            qsync_q[g] <= 1'b0;
            qtok_q[g]  <= 1'b0;
            case (st_q)
               MQF_WAIT: begin
                  qoe_q[g] <= 1'b0;
                  quad_q   <= 2'b00;
                  if (tok || (start_q && mast_q)) begin
                     st_q     <= MQF_RUN;
                     qoe_q[g] <= 1'b1;
                  end
               end
               MQF_RUN: begin
                  quad_q <= quad_q + 2'b01;  // see [R8] [R9]
                  if (quad_q == 2'(`MQF_QUADS - 1)) begin
                     st_q       <= MQF_WAIT;
                     qsync_q[g] <= 1'b1;  // see [R19]
                     qtok_q[g]  <= 1'b1;  // see [R19]
                  end
               end
               default: st_q <= MQF_WAIT;
            endcase
         end
      end

      // polled mode shows the quadrant being stepped, direct the one picked
      always_ff @(posedge core_clk) begin
         if (mrs_act) qbus_q[g] <= 8'hFF;
         else qbus_q[g] <= ~vec[{quad_q, 3'b000} +: 8];  // see [R3] [R4]
      end
   end

   assign empty_quadrant_bus_n = qbus_q[0];
   assign full_quadrant_bus_n  = qbus_q[1];
   assign empty_quadrant_oe    = qoe_q[0];
   assign full_quadrant_oe     = qoe_q[1];
   assign empty_poll_sync      = qsync_q[0];
   assign full_poll_sync       = qsync_q[1];
   assign empty_token_out      = qtok_q[0];
   assign full_token_out       = qtok_q[1];

endmodule

// ===== dv/mqf_top_checker.sv
`timescale 1ns/1ps
module mqf_top_checker (
   input  wire logic        core_clk,              // port clock
   input  wire logic        rst,                   // sync reset
   input  wire logic [7:0]  read_address_bus,      // read address
   input  wire logic        read_queue_latch,      // read select
   input  wire logic        empty_quadrant_strobe, // empty pick
   input  wire logic        full_quadrant_strobe,  // full pick
   input  wire logic [7:0]  write_address_bus,     // write address
   input  wire logic        out_en_n,              // data enable
   input  wire logic        queue_pointer_clear_n, // partial clear
   input  wire logic [2:0]  chain_position_code,   // device code
   input  wire logic        data_out_oe,           // data drive
   input  wire logic        output_valid_flag_n,   // valid flag
   input  wire logic        almost_empty_pin_n,    // empty pin
   input  wire logic        empty_quadrant_oe,     // empty bus drive
   input  wire logic        full_quadrant_oe,      // full bus drive
   input  wire logic        empty_poll_sync,       // empty wrap
   input  wire logic        empty_token_out,       // empty token
   input  wire logic        full_poll_sync,        // full wrap
   input  wire logic        full_token_out         // full token
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // assertions
   property p_oe_off; out_en_n [*4] |-> !data_out_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data driven while disabled");
   property p_foreign;
      read_queue_latch && read_address_bus[7:5] != chain_position_code |-> ##[2:6] output_valid_flag_n;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign read select kept data valid");
   property p_clear;
      $fell(queue_pointer_clear_n) |-> ##[2:8] (output_valid_flag_n && !almost_empty_pin_n);
   endproperty
   a_clear: assert property (p_clear) else $error("cleared queue not empty");
   property p_epick;
      empty_quadrant_strobe && read_address_bus[7:5] == chain_position_code |-> ##[2:6] empty_quadrant_oe;
   endproperty
   a_epick: assert property (p_epick) else $error("empty bus not driven after pick");
   property p_edrop;
      empty_quadrant_strobe && read_address_bus[7:5] != chain_position_code |-> ##[2:6] !empty_quadrant_oe;
   endproperty
   a_edrop: assert property (p_edrop) else $error("empty bus kept after foreign pick");
   property p_fpick;
      full_quadrant_strobe && write_address_bus[7:5] == chain_position_code |-> ##[2:6] full_quadrant_oe;
   endproperty
   a_fpick: assert property (p_fpick) else $error("full bus not driven after pick");
   // after the last quadrant the bus lets go so the next device can drive it
   property p_empty_poll_sync; empty_poll_sync |-> empty_token_out ##1 !empty_quadrant_oe; endproperty
   a_empty_poll_sync: assert property (p_empty_poll_sync) else $error("empty wrap without token or release");
   property p_fsync; full_poll_sync |-> full_token_out ##1 !full_quadrant_oe; endproperty
   a_fsync: assert property (p_fsync) else $error("full wrap without token or release");
   c_poll:  cover property (empty_poll_sync);
   c_clear: cover property ($fell(queue_pointer_clear_n));
   c_pick:  cover property (empty_quadrant_strobe);
endmodule

// ===== dv/mqf_ctl_model.sv
`timescale 1ns/1ps
module mqf_ctl_model (
   input  wire logic        core_clk, // port clock
   output logic      [7:0]  raddr,    // read address
   output logic             rlatch,   // read select
   output logic             estb,     // empty pick
   output logic             ren_n,    // pop
   output logic      [7:0]  waddr,    // write address
   output logic             wlatch,   // write select
   output logic             fstb,     // full pick
   output logic             wen_n,    // push
   output logic      [17:0] din,      // push data
   output logic             pclr_n    // partial clear
);
   initial begin
      {raddr, waddr, din} = '0;
      {rlatch, estb, wlatch, fstb} = '0;
      {ren_n, wen_n, pclr_n} = 3'h7;
   end
   // ==========================================
   // one strobe per call, so latch and pick never share a cycle
   task sel(input logic [1:0] k, input logic [7:0] a);
      @(posedge core_clk);
      if (k[0]) waddr <= a; else raddr <= a;
      case (k)
         2'h0: rlatch <= 1'b1;
         2'h1: wlatch <= 1'b1;
         2'h2: estb <= 1'b1;
         default: fstb <= 1'b1;
      endcase
      @(posedge core_clk);
      {rlatch, wlatch, estb, fstb} <= '0;
      // released bus shows garbage, not the old address
      if (k[0]) waddr <= ~a; else raddr <= ~a;
      repeat (7) @(posedge core_clk);
   endtask
   task push(input logic [17:0] d);
      @(posedge core_clk);
      wen_n <= 1'b0;
      din <= d;
   endtask
   task idle();
      @(posedge core_clk);
      {wen_n, ren_n} <= 2'h3;
      din <= ~din;
      repeat (6) @(posedge core_clk);
   endtask
   task pop();
      @(posedge core_clk);
      ren_n <= 1'b0;
   endtask
   // queue already selected on both ports well before this
   task pclear();
      @(posedge core_clk);
      pclr_n <= 1'b0;
      @(posedge core_clk);
      pclr_n <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import mqf_pkg::*;
   logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, hready;
   logic [7:0] haddr = '0, read_address_bus, write_address_bus, empty_quadrant_bus_n, full_quadrant_bus_n;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2, chain = 3'h2;
   logic [31:0] hwdata = '0, hrdata, rd;
   logic [17:0] data_in, data_out;
   logic read_queue_latch, empty_quadrant_strobe, read_en_n, write_queue_latch, full_quadrant_strobe;
   logic write_en_n, pclr_n, mrs_n = 0, style = 0, out_en_n = 1, data_out_oe, output_valid_flag_n;
   logic output_valid_oe, almost_empty_pin_n, almost_full_pin_n, empty_quadrant_oe, full_quadrant_oe;
   logic empty_poll_sync, empty_token_out, full_poll_sync, full_token_out;
   int errors = 0, total_checks = 0, cyc = 0, ne, nf;
   assign hready = hreadyout;
   always #12.5 core_clk = ~core_clk;
   mqf_ctl_model ctl (.core_clk(core_clk), .raddr(read_address_bus), .rlatch(read_queue_latch),
      .estb(empty_quadrant_strobe), .ren_n(read_en_n), .waddr(write_address_bus), .wlatch(write_queue_latch),
      .fstb(full_quadrant_strobe), .wen_n(write_en_n), .din(data_in), .pclr_n(pclr_n));
   mqf_top #(.DEPTH(4)) uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .read_address_bus(read_address_bus),
      .read_queue_latch(read_queue_latch), .empty_quadrant_strobe(empty_quadrant_strobe),
      .read_en_n(read_en_n), .out_en_n(out_en_n), .write_address_bus(write_address_bus),
      .write_queue_latch(write_queue_latch), .full_quadrant_strobe(full_quadrant_strobe),
      .write_en_n(write_en_n), .data_in(data_in), .queue_pointer_clear_n(pclr_n), .master_reset_n(mrs_n),
      .flag_bus_style(style), .chain_position_code(chain), .master_dev(1'b1),
      .empty_token_in(empty_token_out), .full_token_in(full_token_out), .data_out(data_out),
      .data_out_oe(data_out_oe), .output_valid_flag_n(output_valid_flag_n),
      .output_valid_oe(output_valid_oe), .almost_empty_pin_n(almost_empty_pin_n),
      .almost_full_pin_n(almost_full_pin_n), .empty_quadrant_bus_n(empty_quadrant_bus_n),
      .empty_quadrant_oe(empty_quadrant_oe), .full_quadrant_bus_n(full_quadrant_bus_n),
      .full_quadrant_oe(full_quadrant_oe), .empty_poll_sync(empty_poll_sync),
      .empty_token_out(empty_token_out), .full_poll_sync(full_poll_sync), .full_token_out(full_token_out));
   // ==========================================
   // helpers
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // single AHB-Lite transfer, waits on hready for both phases
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   task mreset(input logic s);
      @(posedge core_clk);
      mrs_n <= 1'b0;
      style <= s;
      repeat (4) @(posedge core_clk);
      mrs_n <= 1'b1;
      // selection only after configuration has settled
      repeat (10) @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         finish_test();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      mreset(1'b0);
      ahb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0000_0202);
      ahb(1'b0, 8'h04, 32'h0);
      check(rd & 32'h01E4_0000, 32'h0140_0000);
      ahb(1'b1, 8'h00, 32'h0000_0101);
      ahb(1'b1, 8'h04, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      out_en_n <= 1'b0;
      ctl.sel(2'h1, 8'h45);
      ctl.push(18'h11111);
      ctl.push(18'h22222);
      ctl.push(18'h33333);
      ctl.idle();
      ctl.sel(2'h3, 8'h40);
      check(almost_full_pin_n, 1'b0);
      check(full_quadrant_oe, 1'b1);
      check(full_quadrant_bus_n, 8'hDF);
      ctl.sel(2'h0, 8'h45);
      check(data_out, 18'h11111);
      check(output_valid_flag_n, 1'b0);
      check(output_valid_oe, 1'b1);
      check(almost_empty_pin_n, 1'b1);
      check(data_out_oe, 1'b1);
      ctl.pop();
      ctl.idle();
      check(data_out, 18'h22222);
      ctl.sel(2'h2, 8'h40);
      check(empty_quadrant_oe, 1'b1);
      check(empty_quadrant_bus_n, 8'h20);
      // foreign code names empty queue 4; a wrong adoption would drop the pin
      ctl.sel(2'h0, 8'h64);
      check(output_valid_flag_n, 1'b1);
      check(output_valid_oe, 1'b0);
      check(almost_empty_pin_n, 1'b1);
      ctl.sel(2'h0, 8'h44);
      check(output_valid_flag_n, 1'b1);
      check(almost_empty_pin_n, 1'b0);
      ctl.sel(2'h0, 8'h45);
      check(data_out, 18'h22222);
      check(output_valid_flag_n, 1'b0);
      ctl.pclear();
      check(output_valid_flag_n, 1'b1);
      check(almost_empty_pin_n, 1'b0);
      check(empty_quadrant_bus_n, 8'h00);
      ahb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0000_0101);
      ctl.sel(2'h2, 8'h60);
      check(empty_quadrant_oe, 1'b0);
      mreset(1'b1);
      ahb(1'b0, 8'h04, 32'h0);
      check(rd[18], 1'b1);
      ne = 0;
      nf = 0;
      repeat (40) begin
         @(posedge core_clk);
         ne += (empty_poll_sync === 1'b1);
         nf += (full_poll_sync === 1'b1);
      end
      check(ne >= 4, 1'b1);
      check(nf >= 4, 1'b1);
      finish_test();
   end
endmodule
bind mqf_top mqf_top_checker chk (.core_clk(core_clk), .rst(rst), .read_address_bus(read_address_bus),
   .read_queue_latch(read_queue_latch), .empty_quadrant_strobe(empty_quadrant_strobe),
   .full_quadrant_strobe(full_quadrant_strobe), .write_address_bus(write_address_bus),
   .out_en_n(out_en_n), .queue_pointer_clear_n(queue_pointer_clear_n),
   .chain_position_code(chain_position_code), .data_out_oe(data_out_oe),
   .output_valid_flag_n(output_valid_flag_n), .almost_empty_pin_n(almost_empty_pin_n),
   .empty_quadrant_oe(empty_quadrant_oe), .full_quadrant_oe(full_quadrant_oe),
   .empty_poll_sync(empty_poll_sync), .empty_token_out(empty_token_out),
   .full_poll_sync(full_poll_sync), .full_token_out(full_token_out));
